// file: core/ctp_pkg.sv
// Package with register map, field layout and carrier types of the prioritizer.
package ctp_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int NUM_TX = 3;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [10:0] OFF_MODULE_CONTROL_0   = 11'h500;
  localparam logic [10:0] OFF_MODULE_CONTROL_1   = 11'h501;
  localparam logic [10:0] OFF_BUS_TIMING_0       = 11'h502;
  localparam logic [10:0] OFF_BUS_TIMING_1       = 11'h503;
  localparam logic [10:0] OFF_RECEIVE_FLAGS      = 11'h504;
  localparam logic [10:0] OFF_RECEIVE_IRQ_ENA    = 11'h505;
  localparam logic [10:0] OFF_TRANSMIT_FLAGS     = 11'h506;
  localparam logic [10:0] OFF_TRANSMIT_CONTROL   = 11'h507;
  localparam logic [10:0] OFF_ACCEPTANCE_CONTROL = 11'h508;
  localparam logic [10:0] OFF_IRQ_STATUS         = 11'h520;
  localparam logic [10:0] OFF_IRQ_MASK           = 11'h521;
  localparam logic [10:0] OFF_TX_PRIO_0          = 11'h55D;
  localparam logic [10:0] OFF_TX_PRIO_1          = 11'h56D;
  localparam logic [10:0] OFF_TX_PRIO_2          = 11'h57D;

  // ---------------------------------------------------------------------
  // Writable bit masks and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] MCR0_WMASK   = 8'h1F;
  localparam logic [7:0] MCR1_WMASK   = 8'h07;
  localparam logic [7:0] ACCEPTANCE_CONTROL_WMASK  = 8'h30;
  localparam logic [7:0] RST_MCR0     = 8'h01;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [2:0] RST_TXE      = 3'h7;
  localparam logic [7:0] RST_PRIO     = 8'h00;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int TXE_LSB   = 0;  // Buffer-empty flags, bits 2:0.
  localparam int ABT_LSB   = 4;  // Abort acknowledge / request, bits 6:4.
  localparam int TX_EMPTY_IRQ_ENABLE_LSB = 0;  // Empty interrupt enables, bits 2:0.
  localparam int IDHIT_LSB = 0;  // Acceptance hit indicator, bits 1:0.
  localparam int EV_DONE   = 0;  // Status bits 2:0: buffer sent.
  localparam int EV_ABORT  = 4;  // Status bits 6:4: buffer aborted.

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [0:0] {
    CTP_IDLE = 1'b0,
    CTP_SEND = 1'b1
  } ctp_tx_e;

  typedef struct packed {
    logic       valid;
    logic [1:0] idx;
  } ctp_sel_s;

  typedef logic [NUM_TX*DATA_W-1:0] ctp_prio_t;

endpackage : ctp_pkg

// file: core/ctp_prio_select.sv
// Lowest-value, lowest-index winner search among pending transmit buffers.
`timescale 1ns/1ns
`default_nettype none

module ctp_prio_select (
  input  wire logic [23:0] i_prio,
  input  wire logic [2:0]  i_elig,
  output logic             o_valid,
  output logic [1:0]       o_idx
);

  logic [2:0] win;

  // -----------------------------------------------------------------------
  // Per-entry comparison
  // -----------------------------------------------------------------------
  // An entry wins when it beats every other eligible entry; at most one can.
  for (genvar i = 0; i < 3; i++) begin : g_ent
    logic [2:0] beats;
    for (genvar j = 0; j < 3; j++) begin : g_cmp
      if (i == j) begin : g_self
        assign beats[j] = 1'b1;
      end else begin : g_other
        assign beats[j] = !i_elig[j]
          || (i_prio[i*8 +: 8] < i_prio[j*8 +: 8])
          || ((i_prio[i*8 +: 8] == i_prio[j*8 +: 8]) && (i < j));
      end
    end
    assign win[i] = i_elig[i] & (&beats);
  end

  // Encode the single winner.
  assign o_valid = |win;
  assign o_idx   = win[2] ? 2'h2 : (win[1] ? 2'h1 : 2'h0);

endmodule : ctp_prio_select

`default_nettype wire

// file: core/ctp_irq_flags.sv
// Sticky interrupt status with write-one-to-clear, mask and level output.
`timescale 1ns/1ns
`default_nettype none

module ctp_irq_flags (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_event,
  input  wire logic [7:0] i_clr,
  input  wire logic       i_mask_wr,
  input  wire logic [7:0] i_mask_wdata,
  output logic [7:0]      o_status,
  output logic [7:0]      o_mask,
  output logic            o_irq
);

  logic [7:0] status_next;
  logic       irq_next;

  // -----------------------------------------------------------------------
  // Sticky bits
  // -----------------------------------------------------------------------
  // A new event in the clearing cycle survives: set has the last word.
  for (genvar b = 0; b < 8; b++) begin : g_bit
    assign status_next[b] = i_event[b] | (o_status[b] & ~i_clr[b]);
  end
  assign irq_next = |(status_next & (i_mask_wr ? i_mask_wdata : o_mask));

  // State update, frozen while the clock enable is low.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_status <= ctp_pkg::RST_ZERO;
      o_mask   <= ctp_pkg::RST_ZERO;
      o_irq    <= 1'b0;
    end else if (i_ce) begin
      o_status <= status_next;
      if (i_mask_wr) begin
        o_mask <= i_mask_wdata;
      end
      o_irq <= irq_next;
    end
  end

endmodule : ctp_irq_flags

`default_nettype wire

// file: core/ctp_tx_prioritizer.sv
// Transmit buffer prioritizer with its control register block.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Eight-bit local priority, smaller is higher.
// - Only buffers with empty flag clear compete.
// - Smallest local priority value wins selection.
// - Equal values: lowest buffer index wins.
// - Three transmit buffers each own a priority.
module ctp_tx_prioritizer (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [10:0]  i_addr,
  input  wire logic [7:0]   i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  input  wire logic         i_sof_req,
  input  wire logic         i_tx_done,
  input  wire logic         i_tx_abort,
  input  wire logic [7:0]   i_rx_flag_set,
  input  wire logic [1:0]   i_id_hit,
  output logic [7:0]        o_rdata,
  output logic              o_irq,
  output ctp_pkg::ctp_sel_s o_sel,
  output logic [2:0]        o_abort_req
);

  // -----------------------------------------------------------------------
  // Register storage
  // -----------------------------------------------------------------------
  logic [7:0]       mcr0_reg;
  logic [7:0]       mcr1_reg;
  logic [7:0]       btr0_reg;
  logic [7:0]       btr1_reg;
  logic [7:0]       rflg_reg;
  logic [7:0]       rier_reg;
  logic [7:0]       acceptance_control_reg;
  logic [2:0]       txe_reg;
  logic [2:0]       abort_acknowledge_reg;
  logic [2:0]       abort_request_reg;
  logic [2:0]       tx_empty_irq_enable_reg;
  ctp_pkg::ctp_prio_t prio_reg;
  ctp_pkg::ctp_tx_e state_reg;
  ctp_pkg::ctp_sel_s sel_reg;
  logic [7:0]       rdata_reg;

  logic [7:0]       rflg_next;
  logic [2:0]       txe_next;
  logic [2:0]       abort_acknowledge_next;
  logic [2:0]       abort_request_next;
  ctp_pkg::ctp_prio_t prio_next;
  ctp_pkg::ctp_tx_e state_next;
  ctp_pkg::ctp_sel_s sel_next;
  logic [7:0]       rdata_next;

  // -----------------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------------
  // Decodes are plain address compares; each write use is qualified with i_wr so that reads never disturb.
  wire hit_mcr0  = (i_addr == ctp_pkg::OFF_MODULE_CONTROL_0);
  wire hit_mcr1  = (i_addr == ctp_pkg::OFF_MODULE_CONTROL_1);
  wire hit_btr0  = (i_addr == ctp_pkg::OFF_BUS_TIMING_0);
  wire hit_btr1  = (i_addr == ctp_pkg::OFF_BUS_TIMING_1);
  wire hit_rflg  = (i_addr == ctp_pkg::OFF_RECEIVE_FLAGS);
  wire hit_rier  = (i_addr == ctp_pkg::OFF_RECEIVE_IRQ_ENA);
  wire hit_tflg  = (i_addr == ctp_pkg::OFF_TRANSMIT_FLAGS);
  wire hit_tctl  = (i_addr == ctp_pkg::OFF_TRANSMIT_CONTROL);
  wire hit_acceptance_control = (i_addr == ctp_pkg::OFF_ACCEPTANCE_CONTROL);
  wire hit_ists  = (i_addr == ctp_pkg::OFF_IRQ_STATUS);
  wire hit_imsk  = (i_addr == ctp_pkg::OFF_IRQ_MASK);
  wire hit_pr0   = (i_addr == ctp_pkg::OFF_TX_PRIO_0);
  wire hit_pr1   = (i_addr == ctp_pkg::OFF_TX_PRIO_1);
  wire hit_pr2   = (i_addr == ctp_pkg::OFF_TX_PRIO_2);

  wire [2:0] hit_pr = {hit_pr2, hit_pr1, hit_pr0};
  wire       wr_tflg = i_wr & hit_tflg;
  wire       wr_tctl = i_wr & hit_tctl;
  wire [2:0] sw_txe_clr = wr_tflg ? i_wdata[ctp_pkg::TXE_LSB +: 3] : 3'h0;

  // -----------------------------------------------------------------------
  // Winner search
  // -----------------------------------------------------------------------
  logic       win_valid;
  logic [1:0] win_idx;

  wire [2:0] elig = ~txe_reg;

  ctp_prio_select u_select (
    .i_prio  (prio_reg),
    .i_elig  (elig),
    .o_valid (win_valid),
    .o_idx   (win_idx)
  );

  // -----------------------------------------------------------------------
  // Frame progress
  // -----------------------------------------------------------------------
  // The engine reports the end of the frame it was handed; done and abort
  // only count while a buffer is in flight.
  wire busy      = (state_reg == ctp_pkg::CTP_SEND);
  wire fin_done  = busy & i_tx_done;
  wire fin_abort = busy & i_tx_abort & ~i_tx_done;
  wire [2:0] cur_onehot = busy ? (3'h1 << sel_reg.idx) : 3'h0;

  // A pending buffer that is not on the wire is withdrawn at once.
  wire [2:0] idle_abort = abort_request_reg & ~txe_reg & ~cur_onehot;
  wire [2:0] ev_done    = fin_done ? cur_onehot : 3'h0;
  wire [2:0] ev_abort   = (fin_abort ? cur_onehot : 3'h0) | idle_abort;

  wire take_sof = i_sof_req & ~busy;

  // Selection and state sequencing.
  always_comb begin
    state_next = state_reg;
    sel_next   = sel_reg;
    if (take_sof) begin
      sel_next.valid = win_valid;
      sel_next.idx   = win_idx;
      state_next     = win_valid ? ctp_pkg::CTP_SEND : ctp_pkg::CTP_IDLE;
    end else if (fin_done || fin_abort) begin
      sel_next.valid = 1'b0;
      state_next     = ctp_pkg::CTP_IDLE;
    end
  end

  // -----------------------------------------------------------------------
  // Transmit flags and control
  // -----------------------------------------------------------------------
  // Hardware setting the empty flag wins over a same-cycle software clear,
  // so a finished frame is never reported as still pending.
  assign txe_next   = (txe_reg & ~sw_txe_clr) | ev_done | ev_abort;
  assign abort_acknowledge_next = (abort_acknowledge_reg & ~sw_txe_clr) | ev_abort;
  assign abort_request_next = (wr_tctl ? i_wdata[ctp_pkg::ABT_LSB +: 3] : abort_request_reg)
                      & ~txe_next;

  // -----------------------------------------------------------------------
  // Local priority registers
  // -----------------------------------------------------------------------
  // one priority per buffer
  for (genvar k = 0; k < ctp_pkg::NUM_TX; k++) begin : g_prio
    assign prio_next[k*8 +: 8] = (i_wr & hit_pr[k]) ? i_wdata
                                                    : prio_reg[k*8 +: 8];
  end

  // Receive flags: engine sets, software clears by writing one.
  assign rflg_next = i_rx_flag_set
                   | (rflg_reg & ~((i_wr & hit_rflg) ? i_wdata : 8'h00));

  // -----------------------------------------------------------------------
  // Interrupt block
  // -----------------------------------------------------------------------
  logic [7:0] irq_status;
  logic [7:0] irq_mask;

  wire [7:0] irq_event = {1'b0, ev_abort, 1'b0, ev_done};
  wire [7:0] irq_clr   = (i_wr & hit_ists) ? i_wdata : 8'h00;

  ctp_irq_flags u_irq (
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (i_rst_n),
    .i_ce         (i_ce),
    .i_event      (irq_event),
    .i_clr        (irq_clr),
    .i_mask_wr    (i_wr & hit_imsk),
    .i_mask_wdata (i_wdata),
    .o_status     (irq_status),
    .o_mask       (irq_mask),
    .o_irq        (o_irq)
  );

  // -----------------------------------------------------------------------
  // Read mux
  // -----------------------------------------------------------------------
  // Unmapped and reserved addresses read as zero.
  wire [7:0] rd_tflg  = {1'b0, abort_acknowledge_reg, 1'b0, txe_reg};
  wire [7:0] rd_tctl  = {1'b0, abort_request_reg, 1'b0, tx_empty_irq_enable_reg};
  wire [7:0] rd_acceptance_control = (acceptance_control_reg & ctp_pkg::ACCEPTANCE_CONTROL_WMASK)
                      | {6'h00, i_id_hit};
  wire [7:0] rd_val =
      hit_mcr0  ? mcr0_reg  :
      hit_mcr1  ? mcr1_reg  :
      hit_btr0  ? btr0_reg  :
      hit_btr1  ? btr1_reg  :
      hit_rflg  ? rflg_reg  :
      hit_rier  ? rier_reg  :
      hit_tflg  ? rd_tflg   :
      hit_tctl  ? rd_tctl   :
      hit_acceptance_control ? rd_acceptance_control  :
      hit_ists  ? irq_status :
      hit_imsk  ? irq_mask  :
      hit_pr0   ? prio_reg[7:0]   :
      hit_pr1   ? prio_reg[15:8]  :
      hit_pr2   ? prio_reg[23:16] : 8'h00;

  // Read data stand only in the cycle after the strobe.
  assign rdata_next = i_rd ? rd_val : 8'h00;

  // -----------------------------------------------------------------------
  // Configuration registers
  // -----------------------------------------------------------------------
  // Plain storage; unimplemented bits are masked on write.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mcr0_reg  <= ctp_pkg::RST_MCR0;
      mcr1_reg  <= ctp_pkg::RST_ZERO;
      btr0_reg  <= ctp_pkg::RST_ZERO;
      btr1_reg  <= ctp_pkg::RST_ZERO;
      rier_reg  <= ctp_pkg::RST_ZERO;
      acceptance_control_reg <= ctp_pkg::RST_ZERO;
      tx_empty_irq_enable_reg <= 3'h0;
    end else if (i_ce && i_wr) begin
      if (hit_mcr0) begin
        mcr0_reg <= i_wdata & ctp_pkg::MCR0_WMASK;
      end
      if (hit_mcr1) begin
        mcr1_reg <= i_wdata & ctp_pkg::MCR1_WMASK;
      end
      if (hit_btr0) begin
        btr0_reg <= i_wdata;
      end
      if (hit_btr1) begin
        btr1_reg <= i_wdata;
      end
      if (hit_rier) begin
        rier_reg <= i_wdata;
      end
      if (hit_acceptance_control) begin
        acceptance_control_reg <= i_wdata & ctp_pkg::ACCEPTANCE_CONTROL_WMASK;
      end
      if (hit_tctl) begin
        tx_empty_irq_enable_reg <= i_wdata[ctp_pkg::TX_EMPTY_IRQ_ENABLE_LSB +: 3];
      end
    end
  end

  // -----------------------------------------------------------------------
  // Transmit state
  // -----------------------------------------------------------------------
  // Empty flags reset set: no buffer competes until software loads one.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      txe_reg   <= ctp_pkg::RST_TXE;
      abort_acknowledge_reg <= 3'h0;
      abort_request_reg <= 3'h0;
      rflg_reg  <= ctp_pkg::RST_ZERO;
      prio_reg  <= {3{ctp_pkg::RST_PRIO}};
      state_reg <= ctp_pkg::CTP_IDLE;
      sel_reg   <= '0;
      rdata_reg <= 8'h00;
    end else if (i_ce) begin
      txe_reg   <= txe_next;
      abort_acknowledge_reg <= abort_acknowledge_next;
      abort_request_reg <= abort_request_next;
      rflg_reg  <= rflg_next;
      prio_reg  <= prio_next;
      state_reg <= state_next;
      sel_reg   <= sel_next;
      rdata_reg <= rdata_next;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // The engine sees all three abort request bits, including a one-cycle request for an idle pending buffer.
  assign o_rdata     = rdata_reg;
  assign o_sel       = sel_reg;
  assign o_abort_req = abort_request_reg;

endmodule : ctp_tx_prioritizer

`default_nettype wire

// file: verification/ctp_tx_prioritizer_properties.sv
// Port-level checker for the transmit buffer prioritizer.
`timescale 1ns/1ns
`default_nettype none

module ctp_tx_prioritizer_properties (
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire logic              i_ce,
  input wire logic [10:0]       i_addr,
  input wire logic [7:0]        i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic              i_sof_req,
  input wire logic              i_tx_done,
  input wire logic              i_tx_abort,
  input wire logic [7:0]        i_rx_flag_set,
  input wire logic [1:0]        i_id_hit,
  input wire logic [7:0]        o_rdata,
  input wire logic              o_irq,
  input wire ctp_pkg::ctp_sel_s o_sel,
  input wire logic [2:0]        o_abort_req
);
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  // All checks share the one clock, and reset hides them.
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  read_idle_zero_a: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  prio_readback_a: assert property (
    i_ce && i_wr && i_addr == ctp_pkg::OFF_TX_PRIO_0 ##1 !i_wr
    ##1 i_ce && i_rd && i_addr == ctp_pkg::OFF_TX_PRIO_0
    |=> o_rdata == $past(i_wdata, 3))
    else $error("local priority did not read back");
  reserved_zero_a: assert property (
    i_ce && i_rd && i_addr == 11'h509 |=> o_rdata == 8'h00)
    else $error("reserved place read non-zero");
  sel_needs_sof_a: assert property (
    $rose(o_sel.valid) |-> $past(i_sof_req) && $past(i_ce))
    else $error("selection appeared without frame start");
  sel_holds_a: assert property (
    o_sel.valid && !i_tx_done && !i_tx_abort
    |=> o_sel.valid && $stable(o_sel.idx))
    else $error("selection changed during a frame");
  done_ends_a: assert property (
    o_sel.valid && i_ce && (i_tx_done || i_tx_abort) |=> !o_sel.valid)
    else $error("selection not released after frame end");
  idx_range_a: assert property (o_sel.valid |-> o_sel.idx != 2'h3)
    else $error("selected index out of range");
  abort_src_a: assert property (
    $rose(|o_abort_req)
    |-> $past(i_wr && i_addr == ctp_pkg::OFF_TRANSMIT_CONTROL))
    else $error("abort request rose without a write");

  cover property (o_sel.valid && i_tx_done);
  cover property (o_sel.valid && i_tx_abort);
  cover property ($rose(o_irq));
endmodule : ctp_tx_prioritizer_properties

bind ctp_tx_prioritizer ctp_tx_prioritizer_properties chk_u (
  .i_ref_clk, .i_rst_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_sof_req, .i_tx_done, .i_tx_abort, .i_rx_flag_set, .i_id_hit,
  .o_rdata, .o_irq, .o_sel, .o_abort_req);

`default_nettype wire

// file: verification/ctp_engine_model.sv
// Behavioural frame engine that asks for a selection and ends frames.
`timescale 1ns/1ns
`default_nettype none

module ctp_engine_model (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_go,
  input  wire logic [3:0]        i_delay,
  input  wire ctp_pkg::ctp_sel_s i_sel,
  input  wire logic [2:0]        i_abort_req,
  output logic                   o_sof_req,
  output logic                   o_tx_done,
  output logic                   o_tx_abort
);
  // ---------------------------------------------------------------------
  // Frame sequencing
  // ---------------------------------------------------------------------
  logic [3:0] cnt_reg;

  // A frame lasts i_delay+1 cycles; an abort request cuts it short.
  // The end pulse is never repeated while the block still shows a frame.
  always_ff @(posedge i_ref_clk) begin
    o_sof_req  <= i_go && !i_sel.valid;
    o_tx_done  <= 1'b0;
    o_tx_abort <= 1'b0;
    if (!i_rst_n) begin
      o_sof_req <= 1'b0;
      cnt_reg   <= 4'h0;
    end else if (i_sel.valid && !o_tx_done && !o_tx_abort) begin
      if (i_abort_req[i_sel.idx]) begin
        o_tx_abort <= 1'b1;
        cnt_reg    <= 4'h0;
      end else if (cnt_reg == i_delay) begin
        o_tx_done <= 1'b1;
        cnt_reg   <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule : ctp_engine_model

`default_nettype wire

// file: verification/ctp_tx_prioritizer_tb.sv
// Self-checking bench for the transmit buffer prioritizer.
`timescale 1ns/1ns
`default_nettype none

module ctp_tx_prioritizer_tb;
  // ---------------------------------------------------------------------
  // Stimulus and checks
  // ---------------------------------------------------------------------
  logic              ref_clk = 1'b0;
  logic              rst_n   = 1'b0;
  logic [10:0]       addr    = 11'h000;
  logic [7:0]        wdata   = 8'h00;
  logic              wr_s    = 1'b0;
  logic              rd_s    = 1'b0;
  logic [7:0]        rxset   = 8'h00;
  logic [1:0]        idhit   = 2'h0;
  logic              go      = 1'b0;
  logic [3:0]        delay   = 4'h0;
  logic              ce      = 1'b1;
  logic              sof, done, abrt, irq;
  logic [7:0]        rdata;
  logic [2:0]        abreq;
  ctp_pkg::ctp_sel_s sel;
  int                bad_count   = 0;
  int                comparisons = 0;

  // Half period of 25 ns gives the 20 MHz clock.
  always #25 ref_clk = ~ref_clk;

  ctp_tx_prioritizer dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .i_sof_req(sof), .i_tx_done(done), .i_tx_abort(abrt),
    .i_rx_flag_set(rxset), .i_id_hit(idhit), .o_rdata(rdata), .o_irq(irq),
    .o_sel(sel), .o_abort_req(abreq));
  ctp_engine_model engine (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_go(go),
    .i_delay(delay), .i_sel(sel), .i_abort_req(abreq), .o_sof_req(sof),
    .o_tx_done(done), .o_tx_abort(abrt));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge.
  task automatic rdc(input logic [10:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rdc

  // Bounded wait, so a lost handshake shows up as a mismatch.
  task automatic wait_sel(input logic v);
    for (int n = 0; n < 60 && sel.valid !== v; n++) @(posedge ref_clk);
    #1;
    chk({7'h0, sel.valid}, {7'h0, v});
  endtask : wait_sel

  task automatic start;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask : start

  task automatic frame(input logic [7:0] pend, input logic [7:0] p0,
                       input logic [7:0] p1, input logic [7:0] p2,
                       input logic [1:0] exp, input logic [7:0] flags);
    wr(ctp_pkg::OFF_TX_PRIO_0, p0);
    wr(ctp_pkg::OFF_TX_PRIO_1, p1);
    wr(ctp_pkg::OFF_TX_PRIO_2, p2);
    if (pend != 8'h00) wr(ctp_pkg::OFF_TRANSMIT_FLAGS, pend);
    start();
    wait_sel(1'b1);
    chk({6'h0, sel.idx}, {6'h0, exp});
    wait_sel(1'b0);
    rdc(ctp_pkg::OFF_TRANSMIT_FLAGS, flags);
  endtask : frame

  task automatic t_reset;
    chk({5'h0, sel}, 8'h00);
    rdc(ctp_pkg::OFF_MODULE_CONTROL_0, 8'h01);
    rdc(ctp_pkg::OFF_TRANSMIT_FLAGS, 8'h07);
    rdc(ctp_pkg::OFF_TX_PRIO_2, 8'h00);
    wr(ctp_pkg::OFF_MODULE_CONTROL_0, 8'hFF);
    rdc(ctp_pkg::OFF_MODULE_CONTROL_0, 8'h1F);
    wr(11'h509, 8'hFF);
    rdc(11'h509, 8'h00);
    rdc(11'h7FF, 8'h00);
    wr(ctp_pkg::OFF_TX_PRIO_0, 8'hA5);
    rdc(ctp_pkg::OFF_TX_PRIO_0, 8'hA5);
    $display("test reset done");
  endtask : t_reset

  task automatic t_lowest;
    frame(8'h07, 8'h30, 8'h10, 8'h20, 2'h1, 8'h02);
    $display("test lowest done");
  endtask : t_lowest

  task automatic t_tie;
    delay <= 4'h6;
    frame(8'h00, 8'h10, 8'h10, 8'h10, 2'h0, 8'h03);
    delay <= 4'h0;
    $display("test tie done");
  endtask : t_tie

  task automatic t_pending;
    frame(8'h02, 8'h05, 8'h05, 8'h05, 2'h1, 8'h03);
    $display("test pending done");
  endtask : t_pending

  task automatic t_bounds;
    frame(8'h03, 8'hFF, 8'hFF, 8'h00, 2'h2, 8'h04);
    $display("test bounds done");
  endtask : t_bounds

  task automatic t_change;
    frame(8'h00, 8'h09, 8'h03, 8'h00, 2'h1, 8'h06);
    frame(8'h00, 8'h09, 8'h03, 8'h00, 2'h0, 8'h07);
    start();
    repeat (4) @(posedge ref_clk);
    chk({7'h0, sel.valid}, 8'h00);
    $display("test change done");
  endtask : t_change

  task automatic t_irq;
    rdc(ctp_pkg::OFF_IRQ_STATUS, 8'h07);
    chk({7'h0, irq}, 8'h00);
    wr(ctp_pkg::OFF_IRQ_MASK, 8'h02);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr(ctp_pkg::OFF_IRQ_STATUS, 8'h02);
    #1;
    chk({7'h0, irq}, 8'h00);
    rdc(ctp_pkg::OFF_IRQ_STATUS, 8'h05);
    $display("test irq done");
  endtask : t_irq

  task automatic t_abort;
    wr(ctp_pkg::OFF_TRANSMIT_FLAGS, 8'h01);
    wr(ctp_pkg::OFF_TRANSMIT_CONTROL, 8'h10);
    rdc(ctp_pkg::OFF_TRANSMIT_FLAGS, 8'h17);
    rdc(ctp_pkg::OFF_TRANSMIT_CONTROL, 8'h00);
    rdc(ctp_pkg::OFF_IRQ_STATUS, 8'h15);
    delay <= 4'hF;
    wr(ctp_pkg::OFF_TRANSMIT_FLAGS, 8'h02);
    start();
    wait_sel(1'b1);
    chk({6'h0, sel.idx}, 8'h01);
    wr(ctp_pkg::OFF_TRANSMIT_CONTROL, 8'h20);
    #1;
    chk({5'h0, abreq}, 8'h02);
    wait_sel(1'b0);
    rdc(ctp_pkg::OFF_TRANSMIT_FLAGS, 8'h37);
    rdc(ctp_pkg::OFF_TRANSMIT_CONTROL, 8'h00);
    $display("test abort done");
  endtask : t_abort

  task automatic t_misc;
    @(posedge ref_clk);
    rxset <= 8'h81;
    idhit <= 2'h2;
    @(posedge ref_clk);
    rxset <= 8'h00;
    rdc(ctp_pkg::OFF_RECEIVE_FLAGS, 8'h81);
    wr(ctp_pkg::OFF_RECEIVE_FLAGS, 8'h01);
    rdc(ctp_pkg::OFF_RECEIVE_FLAGS, 8'h80);
    wr(ctp_pkg::OFF_ACCEPTANCE_CONTROL, 8'hFF);
    rdc(ctp_pkg::OFF_ACCEPTANCE_CONTROL, 8'h32);
    $display("test misc done");
  endtask : t_misc

  // A write seen while the clock enable is low must leave no trace.
  task automatic t_ce;
    wr(ctp_pkg::OFF_BUS_TIMING_0, 8'h5A);
    @(posedge ref_clk);
    ce    <= 1'b0;
    addr  <= ctp_pkg::OFF_BUS_TIMING_0;
    wdata <= 8'hC3;
    wr_s  <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
    ce   <= 1'b1;
    rdc(ctp_pkg::OFF_BUS_TIMING_0, 8'h5A);
    wr(ctp_pkg::OFF_MODULE_CONTROL_1, 8'hFF);
    rdc(ctp_pkg::OFF_MODULE_CONTROL_1, 8'h07);
    $display("test ce done");
  endtask : t_ce

  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // The whole run needs about 200 cycles; the watchdog allows far more.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_lowest();
    t_tie();
    t_pending();
    t_bounds();
    t_change();
    t_irq();
    t_abort();
    t_misc();
    t_ce();
    test_done();
  end
endmodule : ctp_tx_prioritizer_tb

`default_nettype wire
